// ===== common/smbus_seq_pkg.sv
// Constants and types for the serial data sequencer
package smbus_seq_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] CONTROL_INDEX = 8'hC0;
  localparam logic [7:0] CONFIG_INDEX = 8'hC1;
  localparam logic [7:0] DATA_INDEX = 8'hC2;
  localparam logic [7:0] MATCH_INDEX = 8'hC4;
  localparam logic [7:0] MASK_INDEX = 8'hC5;
  localparam int ADDR_WIDTH = 12;
  localparam int INDEX_LSB = 2;
  // Control register fields
  localparam int CTL_MASTER = 7;
  localparam int CTL_TRANSMIT_DIRECTION_FLAG = 6;
  localparam int CTL_START = 5;
  localparam int CTL_HALT = 4;
  localparam int CTL_ACKNOWLEDGE_REQUEST_FLAG = 3;
  localparam int CTL_ERROR = 2;
  localparam int CTL_ACK = 1;
  localparam int CTL_PENDING = 0;
  // Config register fields
  localparam int CFG_ENABLE = 0;
  localparam int CFG_BLOCK = 1;
  localparam int CFG_HWACK = 2;
  // Reset values and last bit index
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] MATCH_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hFE;
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef struct packed {
    logic hardware_acknowledge_enable;
    logic slave_event_block;
    logic enable;
  } config_type;

  typedef struct packed {
    logic rise;
    logic fall;
    logic level;
  } line_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_HOLD_RX,
    ST_ACK_OUT,
    ST_TX,
    ST_TX_ACK,
    ST_POST
  } phase_type;
endpackage

// ===== logic/line_sync.sv
// Two-flop synchroniser with edge detection for one bus line
`timescale 1ns/10ps
`default_nettype none
module line_sync
  import smbus_seq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin,
  output line_type line
);
  logic meta;
  logic stable;
  logic last;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b1;
      stable <= 1'b1;
      last <= 1'b1;
    end else begin
      meta <= pin;
      stable <= meta;
      last <= stable;
    end
  end

  // One driver for the whole struct: rise, fall, level
  assign line = {stable & ~last, ~stable & last, stable};
endmodule
`default_nettype wire

// ===== logic/smbus_slave_data_sequencer.sv
// Slave data sequencer with shift data register and APB registers
// What this block does
// - Data held stable while pending is set
// - Bytes leave most significant bit first
// - First received bit lands in the MSB
// - Bus data shifts in while shifting out
// - Lost arbitration keeps correct byte in data
// - Unblocked START plus address enters slave receive
// - Write address, no hardware ack: flag, software answers
// - Hardware ack: match address, flag after ack
// - Refused address mutes slave until next START
// - No hardware ack: request flag per data byte
// - Hardware ack: preset value answers, then flag
// - STOP ends receive; with hardware ack, data write turns transmitter
// - Master acks each byte; software loads next
// - Write after NACK before clear flags error
// - STOP ends transmit; no write reverts receiver
// - With hardware ack, read transfer flags always after ack cycle
// - Upper control nibble is the status vector
`timescale 1ns/10ps
`default_nettype none
module smbus_slave_data_sequencer
  import smbus_seq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n
);
  line_type scl;
  line_type sda;
  phase_type phase;
  phase_type next_phase;
  config_type cfg;
  logic [7:0] serial_data_byte;
  logic [7:0] slave_address_match;
  logic [7:0] slave_address_mask;
  logic [2:0] bit_count;
  logic transfer_pending_flag;
  logic acknowledge_request_flag;
  logic transmit_direction_flag;
  logic start_request;
  logic halt_condition_request;
  logic ack_value;
  logic error_flag;
  logic address_byte;
  logic read_address;
  logic ack_now;
  logic ack_started;
  logic tx_armed;
  logic master_nack;
  logic sda_drive;
  logic scl_hold;

  // Only bits set in the mask take part in the compare
  function automatic logic address_hit(input logic [7:0] rx, input logic [7:0] match, input logic [7:0] mask);
    address_hit = ((rx[7:1] ^ match[7:1]) & mask[7:1]) == 7'h00;
  endfunction

  line_sync scl_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(scl_in),
    .line(scl)
  );

  line_sync sda_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(sda_in),
    .line(sda)
  );

  // Bus decode
  wire [7:0] index = paddr[INDEX_LSB+7:INDEX_LSB];
  wire aligned = paddr[1:0] == 2'h0 && paddr[ADDR_WIDTH-1:INDEX_LSB+8] == '0;
  wire hit_control = aligned && index == CONTROL_INDEX;
  wire hit_config = aligned && index == CONFIG_INDEX;
  wire hit_data = aligned && index == DATA_INDEX;
  wire hit_match = aligned && index == MATCH_INDEX;
  wire hit_mask = aligned && index == MASK_INDEX;
  wire mapped = hit_control | hit_config | hit_data | hit_match | hit_mask;
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready & pwrite & ~pslverr;
  wire wr_control = wr & hit_control;
  wire wr_config = wr & hit_config;
  wire wr_data = wr & hit_data;

  // Status vector and register images
  wire [3:0] status_vector = {1'b0, transmit_direction_flag, start_request, halt_condition_request};
  wire [7:0] control_image = {status_vector, acknowledge_request_flag, error_flag, ack_value,
    transfer_pending_flag};
  wire [7:0] read_byte = hit_control ? control_image :
    hit_config ? {5'h00, cfg} :
    hit_data ? serial_data_byte :
    hit_match ? slave_address_match :
    hit_mask ? slave_address_mask : 8'h00;

  // Bus events
  wire start_seen = scl.level & sda.fall;
  wire stop_seen = scl.level & sda.rise;
  wire active = cfg.enable;
  wire data_accepted = wr_data & transfer_pending_flag;
  wire pending_clear = wr_control & ~pwdata[CTL_PENDING];
  wire in_slave = phase != ST_IDLE;
  wire byte_done = phase == ST_RX && scl.rise && bit_count == BIT_LAST;
  wire rx_hit = address_hit({serial_data_byte[6:0], sda.level}, slave_address_match, slave_address_mask);
  wire byte_answer = address_byte ? rx_hit : ack_value;
  wire ack_end = phase == ST_ACK_OUT && scl.fall && ack_started;
  wire tx_ack_end = phase == ST_TX_ACK && scl.fall;
  // Posts after a data answer only with hardware ack or a read address; refused address stays mute
  wire post_flag = (ack_end && (ack_now || !address_byte) && (cfg.hardware_acknowledge_enable || read_address)) ||
    tx_ack_end;
  wire hold_flag = byte_done & ~cfg.hardware_acknowledge_enable;
  wire set_pending = hold_flag | post_flag;
  wire resume = transfer_pending_flag & pending_clear;
  // Software answer taken from the clearing write
  wire hold_answer = pwdata[CTL_ACK] & ~read_address;

  // Phase sequencing
  always_comb begin
    next_phase = phase;
    if (!active || stop_seen) begin
      next_phase = ST_IDLE;
    end else if (start_seen) begin
      next_phase = cfg.slave_event_block ? ST_IDLE : ST_RX;
    end else begin
      case (phase)
        ST_IDLE: next_phase = ST_IDLE;
        ST_RX: begin
          if (byte_done) begin
            next_phase = cfg.hardware_acknowledge_enable ? ST_ACK_OUT : ST_HOLD_RX;
          end
        end
        ST_HOLD_RX: begin
          if (resume) begin
            next_phase = ST_ACK_OUT;
          end
        end
        ST_ACK_OUT: begin
          if (ack_end) begin
            if (!ack_now && address_byte) begin
              next_phase = ST_IDLE;
            end else if (post_flag) begin
              next_phase = ST_POST;
            end else begin
              next_phase = ST_RX;
            end
          end
        end
        ST_TX: begin
          // Fall after the eighth rise, counter wrapped
          if (scl.fall && bit_count == 3'h0) begin
            next_phase = ST_TX_ACK;
          end
        end
        ST_TX_ACK: begin
          if (tx_ack_end) begin
            next_phase = ST_POST;
          end
        end
        ST_POST: begin
          if (resume) begin
            next_phase = (tx_armed && !master_nack) ? ST_TX : ST_RX;
          end
        end
        default: next_phase = ST_IDLE;
      endcase
    end
  end

  // Transmit bit drive and stretch hold
  wire tx_last_fall = phase == ST_TX && scl.fall && bit_count == 3'h0;
  wire tx_first = phase == ST_POST && resume && tx_armed && !master_nack;
  wire next_sda_drive = (phase == ST_HOLD_RX && resume) ? hold_answer :
    (phase == ST_ACK_OUT && scl.fall && !ack_started) ? ack_now :
    ack_end ? 1'b0 :
    tx_first ? ~serial_data_byte[7] :
    (phase == ST_TX && scl.fall) ? (tx_last_fall ? 1'b0 : ~serial_data_byte[7]) :
    (next_phase == ST_IDLE) ? 1'b0 : sda_drive;
  // Clock released one cycle after the SDA change, never with it
  wire stretch_phase = phase == ST_HOLD_RX || phase == ST_POST ||
    next_phase == ST_HOLD_RX || next_phase == ST_POST;
  wire next_scl_hold = active && stretch_phase && (scl_hold || !scl.level);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= ST_IDLE;
      sda_drive <= 1'b0;
      scl_hold <= 1'b0;
    end else begin
      phase <= next_phase;
      sda_drive <= next_sda_drive;
      scl_hold <= next_scl_hold;
    end
  end

  // Shift register and bit counter
  wire shift_in = (phase == ST_RX || phase == ST_TX) && scl.rise && !transfer_pending_flag;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_byte <= DATA_RESET;
      bit_count <= 3'h0;
    end else begin
      if (shift_in) begin
        serial_data_byte <= {serial_data_byte[6:0], sda.level};
        bit_count <= bit_count + 3'h1;
      end else if (data_accepted) begin
        serial_data_byte <= pwdata[7:0];
      end
      if (start_seen || (next_phase == ST_RX && phase != ST_RX) || tx_first) begin
        bit_count <= 3'h0;
      end
    end
  end

  // Per-byte flags and direction
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      address_byte <= 1'b0;
      read_address <= 1'b0;
      ack_now <= 1'b0;
      ack_started <= 1'b0;
      tx_armed <= 1'b0;
      master_nack <= 1'b0;
      transmit_direction_flag <= 1'b0;
    end else begin
      if (start_seen) begin
        address_byte <= 1'b1;
        read_address <= 1'b0;
      end else if (ack_end) begin
        address_byte <= 1'b0;
      end
      if (byte_done && address_byte) begin
        read_address <= sda.level;
      end
      if (byte_done) begin
        ack_now <= byte_answer;
      end else if (phase == ST_HOLD_RX && resume) begin
        ack_now <= hold_answer;
      end
      if (phase == ST_ACK_OUT && scl.fall) begin
        ack_started <= ~ack_started;
      end else if (phase == ST_HOLD_RX && resume) begin
        ack_started <= 1'b1;
      end else if (phase != ST_ACK_OUT) begin
        ack_started <= 1'b0;
      end
      if (phase == ST_TX_ACK && scl.rise) begin
        master_nack <= sda.level;
      end else if (phase != ST_TX_ACK && phase != ST_POST) begin
        master_nack <= 1'b0;
      end
      if (data_accepted && in_slave && !(phase == ST_POST && master_nack)) begin
        tx_armed <= 1'b1;
      end else if (next_phase != phase) begin
        tx_armed <= 1'b0;
      end
      if (next_phase == ST_TX) begin
        transmit_direction_flag <= 1'b1;
      end else if (next_phase == ST_RX || next_phase == ST_IDLE) begin
        transmit_direction_flag <= 1'b0;
      end
    end
  end

  // Software-visible control bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      transfer_pending_flag <= 1'b0;
      acknowledge_request_flag <= 1'b0;
      error_flag <= 1'b0;
      ack_value <= 1'b0;
      start_request <= 1'b0;
      halt_condition_request <= 1'b0;
      cfg <= '0;
      slave_address_match <= MATCH_RESET;
      slave_address_mask <= MASK_RESET;
    end else begin
      transfer_pending_flag <= set_pending | (transfer_pending_flag & ~pending_clear);
      acknowledge_request_flag <= hold_flag | (acknowledge_request_flag & ~resume);
      error_flag <= (wr_data && phase == ST_POST && master_nack) |
        (error_flag & ~(wr_control & ~pwdata[CTL_ERROR]));
      if (wr_control) begin
        ack_value <= pwdata[CTL_ACK];
        start_request <= pwdata[CTL_START];
        halt_condition_request <= pwdata[CTL_HALT];
      end
      if (wr_config) begin
        cfg <= config_type'(pwdata[2:0]);
      end
      if (wr & hit_match) begin
        slave_address_match <= pwdata[7:0];
      end
      if (wr & hit_mask) begin
        slave_address_mask <= pwdata[7:0];
      end
    end
  end

  // APB answer, zero wait states
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= {24'h000000, read_byte};
      end
    end
  end

  // Open-drain pins, enables low while pulling low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
      scl_out <= 1'b0;
      scl_oe_n <= 1'b1;
    end else begin
      sda_out <= 1'b0;
      sda_oe_n <= ~next_sda_drive;
      scl_out <= 1'b0;
      scl_oe_n <= ~next_scl_hold;
    end
  end
endmodule
`default_nettype wire

// ===== verif/smbus_slave_data_sequencer_monitor.sv
// Checker on the sequencer ports
`timescale 1ns/10ps
`default_nettype none
module smbus_slave_data_sequencer_monitor
  import smbus_seq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire ctl_hit = paddr == {2'b00, CONTROL_INDEX, 2'b00};
  chk_ready_follows: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_pins_low: assert property (!scl_out && !sda_out) else $error("pin drive value not low");
  chk_stretch_low: assert property ($fell(scl_oe_n) |-> !$past(scl_in, 2)) else $error("stretch on high");
  chk_stretch_release: assert property (pready && pwrite && ctl_hit && !pwdata[CTL_PENDING] |-> ##[1:2] scl_oe_n)
    else $error("clock not released");
  chk_status_master: assert property (pready && !pwrite && ctl_hit |-> !prdata[CTL_MASTER])
    else $error("master flag set");
endmodule
bind smbus_slave_data_sequencer smbus_slave_data_sequencer_monitor mon (.*);
`default_nettype wire

// ===== verif/smbus_master_model.sv
// Two-wire bus master model
`timescale 1ns/10ps
`default_nettype none
module smbus_master_model (
  input wire logic scl_oe_n,
  input wire logic sda_oe_n,
  output logic scl_in,
  output logic sda_in
);
  logic mc = 1'b1;
  logic md = 1'b1;
  // Wired-and lines with pull-ups
  assign scl_in = mc & scl_oe_n;
  assign sda_in = md & sda_oe_n;
  task automatic bit_io(input logic b, output logic s);
    #80 md = b;
    #80 mc = 1'b1;
    wait (scl_in === 1'b1);
    #80 s = sda_in;
    #80 mc = 1'b0;
  endtask
  task automatic start;
    #160 md = 1'b0;
    #160 mc = 1'b0;
  endtask
  task automatic stop;
    #80 md = 1'b0;
    #80 mc = 1'b1;
    #160 md = 1'b1;
    #320;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ma, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ma, s);
    ack = !s;
  endtask
endmodule
`default_nettype wire

// ===== verif/smbus_slave_data_sequencer_bench.sv
// Bench for the slave data sequencer
`timescale 1ns/10ps
`default_nettype none
module smbus_slave_data_sequencer_bench
  import smbus_seq_pkg::*;
;
  typedef struct packed {
    logic w;
    logic [7:0] i;
    logic [7:0] d;
    logic [7:0] x;
    logic e;
  } row_type;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_WIDTH-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, scl_in, scl_out, scl_oe_n, sda_in, sda_out, sda_oe_n, er, ak;
  logic [7:0] rd, q;
  int err_total = 0;
  int checked = 0;
  row_type rows [7] = '{
    '{1'b0, DATA_INDEX, 8'h00, DATA_RESET, 1'b0},
    '{1'b0, MASK_INDEX, 8'h00, MASK_RESET, 1'b0},
    '{1'b1, MATCH_INDEX, 8'h84, 8'h00, 1'b0},
    '{1'b0, MATCH_INDEX, 8'h00, 8'h84, 1'b0},
    '{1'b0, 8'hC3, 8'h00, 8'h00, 1'b1},
    '{1'b1, CONFIG_INDEX, 8'h05, 8'h00, 1'b0},
    '{1'b0, CONFIG_INDEX, 8'h00, 8'h05, 1'b0}
  };
  always #20 mclk = ~mclk;
  smbus_slave_data_sequencer DUT (.*);
  smbus_master_model bus (.*);
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    checked++;
    if (g !== x) begin
      err_total++;
      $display("ERROR %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d, output logic [7:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    apb(1'b1, i, d, rd, er);
  endtask
  task automatic rchk(input logic [7:0] i, input logic [7:0] x);
    apb(1'b0, i, 8'h00, rd, er);
    chk(rd, x);
  endtask
  task automatic pend;
    repeat (300) begin
      apb(1'b0, CONTROL_INDEX, 8'h00, rd, er);
      if (rd[CTL_PENDING] === 1'b1) break;
    end
    chk({7'h00, rd[CTL_PENDING]}, 8'h01);
  endtask
  task automatic send(input logic [7:0] d, input logic x);
    bus.xfer(d, 1'b1, q, ak);
    chk({7'h00, ak}, {7'h00, x});
  endtask
  task automatic end_of_test;
    if (err_total == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #1ms;
    err_total++;
    $display("ERROR %0t: watchdog expired", $time);
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (rows[k]) begin
      apb(rows[k].w, rows[k].i, rows[k].d, rd, er);
      chk({7'h00, er}, {7'h00, rows[k].e});
      if (!rows[k].w) chk(rd, rows[k].x);
    end
    wr(CONTROL_INDEX, 8'h02);
    bus.start;
    send(8'h84, 1'b1);
    pend;
    rchk(DATA_INDEX, 8'h84);
    repeat (20) @(posedge mclk);
    rchk(DATA_INDEX, 8'h84);
    rchk(CONTROL_INDEX, 8'h03);
    wr(CONTROL_INDEX, 8'h02);
    send(8'hA5, 1'b1);
    pend;
    rchk(DATA_INDEX, 8'hA5);
    wr(CONTROL_INDEX, 8'h00);
    send(8'h3C, 1'b0);
    pend;
    wr(CONTROL_INDEX, 8'h02);
    bus.stop;
    bus.start;
    send(8'h90, 1'b0);
    send(8'h84, 1'b0);
    rchk(CONTROL_INDEX, 8'h02);
    bus.stop;
    bus.start;
    send(8'h85, 1'b1);
    pend;
    wr(DATA_INDEX, 8'h5A);
    wr(CONTROL_INDEX, 8'h02);
    rchk(CONTROL_INDEX, 8'h42);
    bus.xfer(8'hFF, 1'b0, q, ak);
    chk(q, 8'h5A);
    pend;
    rchk(DATA_INDEX, 8'h5A);
    wr(DATA_INDEX, 8'hC3);
    wr(CONTROL_INDEX, 8'h02);
    bus.xfer(8'hFF, 1'b1, q, ak);
    chk(q, 8'hC3);
    pend;
    wr(DATA_INDEX, 8'h11);
    apb(1'b0, CONTROL_INDEX, 8'h00, rd, er);
    chk(rd & 8'h04, 8'h04);
    wr(CONTROL_INDEX, 8'h02);
    rchk(CONTROL_INDEX, 8'h02);
    bus.stop;
    wr(CONFIG_INDEX, 8'h01);
    bus.start;
    fork
      send(8'h84, 1'b1);
      begin
        pend;
        chk(rd & 8'h08, 8'h08);
        wr(CONTROL_INDEX, 8'h02);
      end
    join
    fork
      send(8'h77, 1'b0);
      begin
        pend;
        rchk(DATA_INDEX, 8'h77);
        wr(CONTROL_INDEX, 8'h00);
      end
    join
    bus.stop;
    bus.start;
    fork
      send(8'h85, 1'b0);
      begin
        pend;
        wr(CONTROL_INDEX, 8'h00);
      end
    join
    bus.stop;
    wr(CONFIG_INDEX, 8'h03);
    bus.start;
    send(8'h84, 1'b0);
    bus.stop;
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(MATCH_INDEX, MATCH_RESET);
    rchk(MASK_INDEX, MASK_RESET);
    end_of_test;
  end
endmodule
`default_nettype wire
